// ---- hdl/data_operation_unit.sv ----
`timescale 1ns/1ps
`include "event_link_cfg.svh"

module data_operation_unit
  import event_link_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire op_ctrl_t ctrl_i,
  output logic [WIDTH-1:0] result_o,
  output logic flag_o,
  output logic event_o
);

  typedef struct packed {
    logic [WIDTH-1:0] setting;
    logic [WIDTH-1:0] result;
    logic flag;
    logic evt;
  } dou_state_t;

  dou_state_t state_q;
  dou_state_t state_d;

  // ===========================================================
  // operation datapath
  always_comb begin
    logic [WIDTH:0] wide;
    logic cond;
    wide = '0;
    cond = 1'b0;
    state_d = state_q;
    state_d.evt = 1'b0;
    if (ctrl_i.setting_we) begin
      state_d.setting = ctrl_i.wdata[WIDTH-1:0];
    end
    // an input write launches the selected operation
    if (ctrl_i.input_we) begin
      case (ctrl_i.mode)
        OP_ADD: begin
          wide = {1'b0, state_q.setting} + {1'b0, ctrl_i.wdata[WIDTH-1:0]};
          cond = wide[WIDTH]; // overflow past full scale
        end
        OP_SUB: begin
          // measured minus threshold; borrow means below zero
          wide = {1'b0, ctrl_i.wdata[WIDTH-1:0]} - {1'b0, state_q.setting};
          cond = wide[WIDTH];
        end
        default: begin
          wide = '0;
          cond = (ctrl_i.wdata[WIDTH-1:0] == state_q.setting) ^
                 ctrl_i.cmp_on_mismatch;
        end
      endcase
      state_d.result = wide[WIDTH-1:0];
    end
    // a new hit wins over a software clear in the same cycle
    if (ctrl_i.flag_clr) begin
      state_d.flag = 1'b0;
    end
    if (cond) begin
      state_d.flag = 1'b1;
      state_d.evt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign result_o = state_q.result;
  assign flag_o = state_q.flag;
  assign event_o = state_q.evt;

endmodule : data_operation_unit

// ---- hdl/event_link_cfg.svh ----
`ifndef EVENT_LINK_CFG_SVH
`define EVENT_LINK_CFG_SVH

// event numbers of the producers on the linker input side
`define EVT_NONE 8'h00
`define EVT_SNOOZE_REQ 8'h01
`define EVT_TIMER_UNDERFLOW 8'h02
`define EVT_LEVEL_JUDGE 8'h03
`define EVT_COMPARE_MATCH 8'h04
`define EVT_COMPARE_UNMATCH 8'h05
// operation modes of the data operation unit
`define OPMODE_COMPARE 2'h0
`define OPMODE_ADD 2'h1
`define OPMODE_SUB 2'h2
// reset values
`define OPERAND_RESET 16'h0000
`define SELECT_RESET 8'h00
`define PORT_RESET 8'h00

`endif

// ---- hdl/event_link_pkg.sv ----
package event_link_pkg;

  // operation selection of the data operation unit
  typedef enum logic [1:0] {
    OP_COMPARE = 2'b00,
    OP_ADD = 2'b01,
    OP_SUB = 2'b10,
    OP_RSVD = 2'b11
  } op_mode_t;

  // operation control: mode, compare polarity, write strobes
  typedef struct packed {
    op_mode_t mode;
    logic cmp_on_mismatch;
    logic setting_we;
    logic input_we;
    logic flag_clr;
    logic [15:0] wdata;
  } op_ctrl_t;

  // per port group set and reset masks
  typedef struct packed {
    logic [7:0] set_mask;
    logic [7:0] rst_mask;
  } port_ctrl_t;

  // port data write port
  typedef struct packed {
    logic we;
    logic [7:0] data;
  } port_wr_t;

endpackage : event_link_pkg

// ---- hdl/event_linker.sv ----
`timescale 1ns/1ps
`include "event_link_cfg.svh"


module event_linker
  import event_link_pkg::*;
#(
  parameter int CONSUMERS = 3,
  parameter int PORT_W = 8,
  parameter int ADC_W = 12
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic global_link_enable_i,
  input wire logic [7:0] sel_conv_start_i,
  input wire logic [7:0] sel_port1_i,
  input wire logic [7:0] sel_port2_i,
  input wire logic snooze_req_i,
  input wire logic timer_underflow_i,
  input wire op_ctrl_t op_ctrl_i,
  input wire logic conv_done_i,
  input wire logic [ADC_W-1:0] conv_result_i,
  input wire logic [ADC_W-1:0] cmp_ref_i,
  input wire logic cmp_greater_i,
  input wire port_ctrl_t port1_ctrl_i,
  input wire port_ctrl_t port2_ctrl_i,
  input wire port_wr_t port1_wr_i,
  input wire port_wr_t port2_wr_i,
  output logic conv_start_o,
  output logic operation_result_flag_o,
  output logic [15:0] op_result_o,
  output logic compare_match_event_o,
  output logic [PORT_W-1:0] port1_out_o,
  output logic [PORT_W-1:0] port2_out_o
);

  // ===========================================================
  // state
  typedef struct packed {
    logic conv_start;
    logic cmp_match;
    logic cmp_unmatch;
    logic [CONSUMERS-1:0] routed;
    logic [PORT_W-1:0] port1;
    logic [PORT_W-1:0] port2;
  } link_state_t;

  link_state_t state_q;
  link_state_t state_d;

  logic level_judge_event;
  logic dou_flag;
  logic [15:0] dou_result;
  logic [7:0] producer_evt [0:7];
  logic [7:0] sel [0:CONSUMERS-1];
  logic [CONSUMERS-1:0] hit;

  // ===========================================================
  // data operation unit
  data_operation_unit #(
    .WIDTH(16)
  ) u_dou (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .ctrl_i(op_ctrl_i),
    .result_o(dou_result),
    .flag_o(dou_flag),
    .event_o(level_judge_event)
  );

  // ===========================================================
  // timing through the linker, counted in system clock edges
  //
  // a producer pulse sampled at edge n is matched against every
  // consumer select in the same cycle, so the routed pulse is
  // registered at edge n. consumers that act on it (the port
  // groups) then change their own flops one edge later.
  //
  // the level judge path is one stage longer: the operation unit
  // registers its own event first, so an input write at edge n
  // shows on the port pins after edge n+2.
  //
  // the compare unit is modelled here as well; its match and
  // unmatch pulses are registered before they enter the table,
  // which gives the same depth as the level judge path.
  //
  // limitation: producers must already be single-cycle pulses in
  // this clock domain; a level held high is routed every cycle.

  // ===========================================================
  // producer table, indexed by event number; unused slots read 0,
  // and the range check in each selector keeps an out-of-table number from aliasing onto a producer
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      producer_evt[k] = 8'h00;
    end
    // low power snooze request
    producer_evt[int'(`EVT_SNOOZE_REQ)] = {7'h00, snooze_req_i};
    // periodic timer underflow
    producer_evt[int'(`EVT_TIMER_UNDERFLOW)] =
      {7'h00, timer_underflow_i};
    // level judgement from the operation unit
    producer_evt[int'(`EVT_LEVEL_JUDGE)] =
      {7'h00, level_judge_event};
    // converter compare hit and miss
    producer_evt[int'(`EVT_COMPARE_MATCH)] =
      {7'h00, state_q.cmp_match};
    producer_evt[int'(`EVT_COMPARE_UNMATCH)] =
      {7'h00, state_q.cmp_unmatch};
  end

  assign sel[0] = sel_conv_start_i;
  assign sel[1] = sel_port1_i;
  assign sel[2] = sel_port2_i;

  // ===========================================================
  // one selector per consumer; selects are read live, so software
  // may repoint a consumer between events without any handshake
  genvar g;
  generate
    for (g = 0; g < CONSUMERS; g++) begin : g_route
      always_comb begin
        hit[g] = 1'b0;
        // zero or out-of-table numbers route nothing
        if (sel[g] != `EVT_NONE && sel[g] <= `EVT_COMPARE_UNMATCH) begin
          hit[g] = producer_evt[sel[g][2:0]][0] &
                   global_link_enable_i;
        end
      end
    end
  endgenerate

  // ===========================================================
  // next state
  // the compare unit and both port groups share one state word so
  // that a single register process holds every flop of the block outside the operation unit;
  // the port groups read the routed pulse from the previous cycle,
  // which keeps the select decode out of the port data path
  always_comb begin
    logic lo;
    logic hi;
    state_d = state_q;
    lo = conv_result_i < cmp_ref_i;
    hi = conv_result_i > cmp_ref_i;
    // compare unit: one pulse per finished conversion
    state_d.cmp_match = conv_done_i & (cmp_greater_i ? hi : lo);
    state_d.cmp_unmatch = conv_done_i & ~(cmp_greater_i ? hi : lo);
    // routed events leave as one-cycle pulses
    state_d.routed = hit;
    state_d.conv_start = hit[0];
    // port groups: software write, then event set and reset
    if (port1_wr_i.we) begin
      state_d.port1 = port1_wr_i.data;
    end
    if (port2_wr_i.we) begin
      state_d.port2 = port2_wr_i.data;
    end
    // an event wins over a same-cycle software write
    if (state_q.routed[1]) begin
      state_d.port1 = (state_d.port1 | port1_ctrl_i.set_mask) &
                      ~port1_ctrl_i.rst_mask;
    end
    if (state_q.routed[2]) begin
      state_d.port2 = (state_d.port2 | port2_ctrl_i.set_mask) &
                      ~port2_ctrl_i.rst_mask;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ===========================================================
  // outputs straight from flip-flops
  // the flag and the result come from flops inside the operation
  // unit, so no logic sits between any flop and a top-level pin
  assign conv_start_o = state_q.conv_start;
  assign compare_match_event_o = state_q.cmp_match;
  assign port1_out_o = state_q.port1;
  assign port2_out_o = state_q.port2;
  assign operation_result_flag_o = dou_flag;
  assign op_result_o = dou_result;

endmodule : event_linker

// ---- tb/event_linker_assertions.sv ----
`timescale 1ns/1ps
module event_linker_assertions
  import event_link_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic global_link_enable_i,
  input wire logic [7:0] sel_conv_start_i,
  input wire logic snooze_req_i,
  input wire logic timer_underflow_i,
  input wire op_ctrl_t op_ctrl_i,
  input wire port_ctrl_t port1_ctrl_i,
  input wire port_wr_t port1_wr_i,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_result_i,
  input wire logic [11:0] cmp_ref_i,
  input wire logic cmp_greater_i,
  input wire logic compare_match_event_o,
  input wire logic conv_start_o,
  input wire logic operation_result_flag_o,
  input wire logic [7:0] port1_out_o
);
  // ====
  // link, flag, port and compare checks
  wire on = global_link_enable_i;
  wire s0 = sel_conv_start_i == 8'h00;
  wire s1 = on && sel_conv_start_i == 8'h01;
  wire s2 = on && sel_conv_start_i == 8'h02;
  wire flag = operation_result_flag_o;
  wire clr = op_ctrl_i.flag_clr;
  wire wr = op_ctrl_i.input_we;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  property p_snooze; s1 && snooze_req_i |=> conv_start_o; endproperty
  a_snooze: assert property (p_snooze) else $error("no start");
  property p_timer; s2 && timer_underflow_i |=> conv_start_o; endproperty
  a_timer: assert property (p_timer) else $error("no start");
  property p_gate; !on [*3] |=> !conv_start_o; endproperty
  a_gate: assert property (p_gate) else $error("start when off");
  property p_none; s0 [*3] |=> !conv_start_o; endproperty
  a_none: assert property (p_none) else $error("stray start");
  property p_rise; $rose(flag) |-> $past(wr); endproperty
  a_rise: assert property (p_rise) else $error("stray flag");
  property p_keep; flag && !clr |=> flag; endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_clr; clr && !wr |=> !flag; endproperty
  a_clr: assert property (p_clr) else $error("flag kept");
  property p_hold; !$past(port1_wr_i.we) && $past(port1_ctrl_i) == '0
    |-> $stable(port1_out_o); endproperty
  a_hold: assert property (p_hold) else $error("port moved");
  property p_match; conv_done_i && cmp_greater_i &&
    conv_result_i > cmp_ref_i |=> compare_match_event_o; endproperty
  a_match: assert property (p_match) else $error("no match");
  property p_nomatch; !conv_done_i |=> !compare_match_event_o; endproperty
  a_nomatch: assert property (p_nomatch) else $error("stray match");
endmodule : event_linker_assertions
bind event_linker event_linker_assertions i_event_linker_assertions (.*);

// ---- tb/event_source_model.sv ----
`timescale 1ns/1ps
module event_source_model (
  input wire logic clk_sys_i,
  input wire logic [1:0] fire_i,
  input wire logic conv_start_i,
  output logic snooze_req_o = 1'b0,
  output logic timer_underflow_o = 1'b0,
  output int starts_o = 0
);
  // ====
  // producers pulse one edge after a request; converter counts starts
  always @(posedge clk_sys_i) begin
    snooze_req_o <= fire_i[0];
    timer_underflow_o <= fire_i[1];
    if (conv_start_i) starts_o <= starts_o + 1;
  end
endmodule : event_source_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("FAIL %s exp %0h got %0h", n, e, g); end end
module tb_top
  import event_link_pkg::*;
;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, global_link_enable_i = 1'b0;
  logic snooze_req_i, timer_underflow_i, conv_done_i = 1'b0;
  logic cmp_greater_i = 1'b1, conv_start_o, operation_result_flag_o;
  logic compare_match_event_o;
  logic [7:0] sel_conv_start_i = 8'h00, sel_port1_i = 8'h03;
  logic [7:0] sel_port2_i = 8'h04, port1_out_o, port2_out_o;
  logic [11:0] conv_result_i = 12'h800, cmp_ref_i = 12'h400;
  logic [15:0] op_result_o;
  op_ctrl_t op_ctrl_i = '0;
  port_ctrl_t port1_ctrl_i = '0, port2_ctrl_i = '{8'h81, 8'h00};
  port_wr_t port1_wr_i = '0, port2_wr_i = '0;
  logic [1:0] fire = 2'b00;
  int starts, fail_count = 0, total_checks = 0;
  // ====
  // clock, unit and producers
  initial forever #10 clk_sys_i = ~clk_sys_i;
  event_linker i_event_linker (.*);
  event_source_model i_event_source_model (.clk_sys_i(clk_sys_i),
    .fire_i(fire), .conv_start_i(conv_start_o), .snooze_req_o(snooze_req_i),
    .timer_underflow_o(timer_underflow_i), .starts_o(starts));
  // one request, then wait out the three-stage route to the port pins
  task automatic op_req(input op_mode_t m, input logic [2:0] w,
    input logic [15:0] d);
    @(posedge clk_sys_i);
    op_ctrl_i <= '{m, 1'b0, w[2], w[1], w[0], d};
    @(posedge clk_sys_i);
    op_ctrl_i <= '0;
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask : op_req
  task automatic start_case(input logic e, input logic [7:0] s,
    input logic [1:0] f, input int n);
    @(posedge clk_sys_i);
    global_link_enable_i <= e;
    sel_conv_start_i <= s;
    fire <= f;
    @(posedge clk_sys_i);
    fire <= 2'b00;
    repeat (4) @(posedge clk_sys_i);
    #1 `CHK("starts", n, starts)
  endtask : start_case
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // ====
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    #1 `CHK("port1", 8'h00, port1_out_o)
    start_case(1'b1, 8'h01, 2'b01, 1);
    start_case(1'b1, 8'h02, 2'b10, 2);
    start_case(1'b1, 8'h02, 2'b01, 2);
    start_case(1'b0, 8'h01, 2'b01, 2);
    start_case(1'b1, 8'h00, 2'b01, 2);
    @(posedge clk_sys_i);
    port1_wr_i <= '{1'b1, 8'hF0};
    port1_ctrl_i <= '{8'h0F, 8'h30};
    @(posedge clk_sys_i);
    port1_wr_i <= '0;
    op_req(OP_SUB, 3'b100, 16'h0100);
    op_req(OP_SUB, 3'b010, 16'h00FF);
    `CHK("flag", 1'b1, operation_result_flag_o)
    `CHK("diff", 16'hFFFF, op_result_o)
    `CHK("port1", 8'hCF, port1_out_o)
    op_req(OP_SUB, 3'b001, 16'h0000);
    op_req(OP_SUB, 3'b010, 16'h0180);
    `CHK("flag", 1'b0, operation_result_flag_o)
    `CHK("diff", 16'h0080, op_result_o)
    op_req(OP_ADD, 3'b010, 16'hFF00);
    `CHK("flag", 1'b1, operation_result_flag_o)
    `CHK("sum", 16'h0000, op_result_o)
    op_req(OP_COMPARE, 3'b001, 16'h0000);
    `CHK("flag", 1'b0, operation_result_flag_o)
    op_req(OP_COMPARE, 3'b010, 16'h0100);
    `CHK("flag", 1'b1, operation_result_flag_o)
    `CHK("port1", 8'hCF, port1_out_o)
    @(posedge clk_sys_i);
    conv_done_i <= 1'b1;
    @(posedge clk_sys_i);
    conv_done_i <= 1'b0;
    #1 `CHK("match", 1'b1, compare_match_event_o)
    repeat (3) @(posedge clk_sys_i);
    #1 `CHK("port2", 8'h81, port2_out_o)
    `CHK("match", 1'b0, compare_match_event_o)
    @(posedge clk_sys_i);
    sel_port2_i <= 8'h05;
    port2_ctrl_i <= '{8'h00, 8'h01};
    conv_result_i <= 12'h100;
    conv_done_i <= 1'b1;
    @(posedge clk_sys_i);
    conv_done_i <= 1'b0;
    #1 `CHK("match", 1'b0, compare_match_event_o)
    repeat (3) @(posedge clk_sys_i);
    #1 `CHK("port2", 8'h80, port2_out_o)
    tally_and_finish();
  end
endmodule : tb_top
